// File: tb_tfp_regs.sv
// self-checking bench for tfp_regs
// assumes tfp_host.sv and tfp_regs_asserts.sv compiled before it
`default_nettype none
module tb_tfp_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // stimulus and checks
    // ----------------
    // rows: res, local frac, remote frac, expected local low byte
    localparam logic [19:0] ROWS [8] = '{20'h0FA80, 20'h1F5C0,
        20'h2F3E0, 20'h3F1F0, 20'h23020, 20'h17F40, 20'h07E00, 20'h31210};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mv = 1'b0;
    logic [3:0] lf = 4'h0;
    logic [3:0] rf = 4'h0;
    logic [7:0] li = 8'h00;
    logic [7:0] ri = 8'h00;
    logic [7:0] d;
    logic [19:0] r;
    logic pw, dw, rdq, rv, ws;
    logic [7:0] wd, ptr, rdat, wa, wdo;
    logic [1:0] res;
    int err_total = 0;
    int n_compared = 0;
    always #2 clk = ~clk;
    tfp_host host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv),
        .ptr_wr_o(pw), .data_wr_o(dw), .rd_o(rdq), .wdata_o(wd));
    tfp_regs uut (.core_clk_i(clk), .rstn_i(rstn), .meas_valid_i(mv),
        .loc_int_i(li), .loc_frac_i(lf), .rem_int_i(ri), .rem_frac_i(rf),
        .ptr_wr_i(pw), .data_wr_i(dw), .rd_i(rdq), .wdata_i(wd),
        .ptr_o(ptr), .rdata_o(rdat), .rvalid_o(rv), .wr_strobe_o(ws),
        .wr_addr_o(wa), .wr_data_o(wdo), .local_resolution_select_o(res));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d of %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk(ptr, 8'h00);
        host.get(8'h1A, d);
        chk(d, 8'h1C);
        for (int i = 0; i < 8; i++)
        begin
            r = ROWS[i];
            host.wr(1'b1, 8'h1A);
            host.wr(1'b0, {6'h00, r[17:16]});
            #1 chk(wa, 8'h1A);
            chk(wdo, {6'h00, r[17:16]});
            chk({ws, 5'h00, res}, {1'h1, 5'h00, r[17:16]});
            @(posedge clk);
            mv <= 1'b1;
            lf <= r[15:12];
            rf <= r[11:8];
            li <= {4'h1, r[15:12]};
            ri <= {4'h6, r[11:8]};
            @(posedge clk);
            mv <= 1'b0;
            host.get(8'h15, d);
            chk(d, r[7:0]);
            host.get(8'h10, d);
            chk(d, {r[11:8], 4'h0});
            host.get(8'h00, d);
            chk(d, {4'h1, r[15:12]});
            host.get(8'h01, d);
            chk(d, {4'h6, r[11:8]});
        end
        host.rd(d);
        chk(d, 8'h62);
        chk(ptr, 8'h01);
        host.get(8'hFF, d);
        chk(d, 8'h00);
        chk(ptr, 8'hFF);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1 chk(ptr, 8'h00);
        close_out;
    end
    initial
    begin
        #20000;
        err_total++;
        close_out;
    end
endmodule
bind tfp_regs tfp_regs_asserts chk_i (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .ptr_wr_i(ptr_wr_i), .data_wr_i(data_wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .ptr_o(ptr_o), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .wr_strobe_o(wr_strobe_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .local_resolution_select_o(local_resolution_select_o));
`default_nettype wire

// File: tfp_consts.svh
// constants for the temperature fraction and register pointer block
// assumes inclusion by bare name from package and design files
`ifndef TFP_CONSTS_SVH
`define TFP_CONSTS_SVH

// ----------------------------------------------------------------
// pointer register
// ----------------------------------------------------------------
`define TFP_PTR_W 8
`define TFP_PTR_RST 8'h00

// ----------------------------------------------------------------
// fraction formats
// ----------------------------------------------------------------
`define TFP_FRAC_W 4
`define TFP_FRAC_POS 4
`define TFP_RES_W 2
`define TFP_RES_HALF 2'h0
`define TFP_RES_QUARTER 2'h1
`define TFP_RES_EIGHTH 2'h2
`define TFP_RES_SIXTEENTH 2'h3
// the resolution byte powers up at the coarsest local format
`define TFP_RES_RST 2'h0
`define TFP_RES_FIXED 6'h07
`define TFP_MASK_HALF 8'h80
`define TFP_MASK_QUARTER 8'hC0
`define TFP_MASK_EIGHTH 8'hE0
`define TFP_MASK_SIXTEENTH 8'hF0

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define TFP_ADDR_LOC_HI 8'h00
`define TFP_ADDR_REM_HI 8'h01
`define TFP_ADDR_REM_LO 8'h10
`define TFP_ADDR_LOC_LO 8'h15
`define TFP_ADDR_RES 8'h1A

`endif

// File: tfp_frac_fmt.sv
// fraction byte formatter: keeps the top fraction bits for a resolution
// assumes res_i is one of the four resolution codes
`default_nettype none
`include "tfp_consts.svh"

module tfp_frac_fmt
(
    // raw fraction in sixteenths
    input wire logic [`TFP_FRAC_W-1:0] frac_i,
    input wire logic [`TFP_RES_W-1:0] res_i,
    // formatted low byte
    output logic [7:0] low_o
);
    logic [7:0] raw;
    logic [7:0] mask;

    assign raw = {frac_i, {`TFP_FRAC_POS{1'b0}}};

    // masking truncates downward; no rounding is wanted
    always_comb
    begin
        case (res_i)
            `TFP_RES_HALF: mask = `TFP_MASK_HALF;
            `TFP_RES_QUARTER: mask = `TFP_MASK_QUARTER;
            `TFP_RES_EIGHTH: mask = `TFP_MASK_EIGHTH;
            default: mask = `TFP_MASK_SIXTEENTH;
        endcase
    end

    assign low_o = raw & mask;
endmodule

`default_nettype wire

// File: tfp_host.sv
// serial host model issuing decoded command strobes
// assumes its tasks are called by the bench, one at a time
`default_nettype none
module tfp_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output logic ptr_wr_o,
    output logic data_wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // commands
    // ----------------
    initial
    begin
        ptr_wr_o = 1'b0;
        data_wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // an idle edge always precedes a command, so no double assignment
    task automatic wr(input logic p, input logic [7:0] b);
        @(posedge clk_i);
        ptr_wr_o <= p;
        data_wr_o <= !p;
        wdata_o <= b;
        @(posedge clk_i);
        ptr_wr_o <= 1'b0;
        data_wr_o <= 1'b0;
        wdata_o <= ~b; // released byte must not look valid
    endtask
    task automatic rd(output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        // a missing valid reads as unknown so the compare fails
        #1 d = rvalid_i ? rdata_i : 8'hXX;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        wr(1'b1, a);
        rd(d);
    endtask
endmodule
`default_nettype wire

// File: tfp_pkg.sv
// types for the temperature fraction and register pointer block
// assumes tfp_consts.svh is on the include path
`default_nettype none
`include "tfp_consts.svh"

package tfp_pkg;
    typedef logic [`TFP_PTR_W-1:0] tfp_ptr_t;
    typedef logic [7:0] tfp_byte_t;

    typedef enum logic [1:0] {
        TFP_IDLE,
        TFP_PTR_LOADED,
        TFP_DATA_WRITE
    } tfp_cmd_e;

    typedef struct packed {
        tfp_ptr_t ptr;
        tfp_byte_t loc_lo;
        tfp_byte_t rem_lo;
        tfp_byte_t loc_hi;
        tfp_byte_t rem_hi;
        tfp_byte_t rd_data;
        logic rd_valid;
        logic wr_strobe;
        tfp_byte_t wr_data;
        tfp_ptr_t wr_addr;
        logic [`TFP_RES_W-1:0] res;
        tfp_cmd_e phase;
    } tfp_state_s;
endpackage

`default_nettype wire

// File: tfp_regs.sv
// temperature result bytes and register pointer of a dual monitor;
// holds the resolution byte itself and hands every data write, that one too, on
// through wr_strobe_o to the rest of the register file
// assumes a serial front end that decodes commands into one-cycle
// strobes: ptr_wr (pointer byte), data_wr (data byte), rd (read)
// assumes result inputs are stable while meas_valid_i is high
//
// Operation
// - remote low byte: sixteenths in bits 7..4
// - local low byte keeps top bits per resolution
// - coarser local resolutions truncate, never round
// - eight-bit pointer selects addressed data register
// - reads and writes act on selected register
// - only a pointer-byte write command loads a new pointer
// - pointer is zero after power-on reset
// - high byte holds whole degrees, low byte fraction
// - local resolution selectable, remote fixed sixteenth
`default_nettype none
`include "tfp_consts.svh"

module tfp_regs
#(
    // pointer width and register addresses
    parameter int PTR_W = `TFP_PTR_W,
    parameter logic [PTR_W-1:0] LOC_HI_ADDR = `TFP_ADDR_LOC_HI,
    parameter logic [PTR_W-1:0] REM_HI_ADDR = `TFP_ADDR_REM_HI,
    parameter logic [PTR_W-1:0] REM_LO_ADDR = `TFP_ADDR_REM_LO,
    parameter logic [PTR_W-1:0] LOC_LO_ADDR = `TFP_ADDR_LOC_LO,
    parameter logic [PTR_W-1:0] RES_ADDR = `TFP_ADDR_RES
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // measurement results
    input wire logic meas_valid_i,
    input wire logic [7:0] loc_int_i,
    input wire logic [`TFP_FRAC_W-1:0] loc_frac_i,
    input wire logic [7:0] rem_int_i,
    input wire logic [`TFP_FRAC_W-1:0] rem_frac_i,
    // decoded serial commands
    input wire logic ptr_wr_i,
    input wire logic data_wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    // answers
    output logic [PTR_W-1:0] ptr_o,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic wr_strobe_o,
    output logic [PTR_W-1:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [`TFP_RES_W-1:0] local_resolution_select_o
);
    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the state struct carries a fixed eight-bit pointer, so another
    // width could not be stored without losing bits
    if (PTR_W != `TFP_PTR_W)
    begin : g_bad_width
        $error("pointer width must be eight");
    end

    // the formatter shifts the fraction up against bit 7, so field
    // and offset must fill the byte exactly
    if (`TFP_FRAC_W + `TFP_FRAC_POS != 8)
    begin : g_bad_frac
        $error("fraction field must fill the low byte");
    end

    // the formatter decodes exactly four resolution codes
    if (`TFP_RES_W != 2)
    begin : g_bad_res
        $error("resolution field must be two bits");
    end

    // two registers on one address would shadow each other in the
    // read mux, the first case item always winning
    if (LOC_HI_ADDR == REM_HI_ADDR ||
        LOC_HI_ADDR == REM_LO_ADDR ||
        LOC_HI_ADDR == LOC_LO_ADDR ||
        LOC_HI_ADDR == RES_ADDR ||
        REM_HI_ADDR == REM_LO_ADDR ||
        REM_HI_ADDR == LOC_LO_ADDR ||
        REM_HI_ADDR == RES_ADDR ||
        REM_LO_ADDR == LOC_LO_ADDR ||
        REM_LO_ADDR == RES_ADDR ||
        LOC_LO_ADDR == RES_ADDR)
    begin : g_bad_map
        $error("register addresses must be distinct");
    end

    // ----------------------------------------------------------------
    // formatting
    // ----------------------------------------------------------------
    // whole block state lives in one struct, registered below
    tfp_pkg::tfp_state_s s_q;
    tfp_pkg::tfp_state_s s_d;
    logic [7:0] loc_lo_fmt;
    logic [7:0] rem_lo_fmt;
    logic [7:0] sel;
    logic [7:0] res_byte;
    logic hit_res;

    // local format follows the stored resolution code
    tfp_frac_fmt u_loc_fmt
    (
        .frac_i(loc_frac_i),
        .res_i(s_q.res),
        .low_o(loc_lo_fmt)
    );

    // remote channel is always at full resolution
    tfp_frac_fmt u_rem_fmt
    (
        .frac_i(rem_frac_i),
        .res_i(`TFP_RES_SIXTEENTH),
        .low_o(rem_lo_fmt)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    // the fixed upper bits of the resolution byte read as 6'h07; only
    // the two code bits are writable
    assign res_byte = {`TFP_RES_FIXED, s_q.res};
    assign hit_res = (s_q.ptr == RES_ADDR);

    // ----------------------------------------------------------------
    // read selection
    // ----------------------------------------------------------------
    always_comb
    begin
        case (s_q.ptr)
            LOC_HI_ADDR: sel = s_q.loc_hi;
            REM_HI_ADDR: sel = s_q.rem_hi;
            LOC_LO_ADDR: sel = s_q.loc_lo;
            REM_LO_ADDR: sel = s_q.rem_lo;
            RES_ADDR: sel = res_byte;
            // unmapped and write-only addresses read zero
            default: sel = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        // strobes default low so each answer stands one cycle
        s_d = s_q;
        s_d.rd_valid = 1'b0;
        s_d.wr_strobe = 1'b0;
        if (meas_valid_i)
        begin
            s_d.loc_hi = loc_int_i;
            s_d.rem_hi = rem_int_i;
            // results latch with the format in force at capture time
            s_d.loc_lo = loc_lo_fmt;
            s_d.rem_lo = rem_lo_fmt;
        end
        // pointer byte beats data byte beats read; the front end never
        // sends two in one cycle, so the loser is simply dropped
        if (ptr_wr_i)
        begin
            s_d.ptr = wdata_i;
            s_d.phase = tfp_pkg::TFP_PTR_LOADED;
        end
        else if (data_wr_i)
        begin
            // data byte goes to the register the pointer holds
            s_d.wr_strobe = 1'b1;
            s_d.wr_addr = s_q.ptr;
            s_d.wr_data = wdata_i;
            s_d.phase = tfp_pkg::TFP_DATA_WRITE;
            if (hit_res)
            begin
                s_d.res = wdata_i[`TFP_RES_W-1:0];
            end
        end
        else if (rd_i)
        begin
            // a bare read reuses the stored pointer
            // rdata holds until the next read, not only while rvalid is up
            s_d.rd_data = sel;
            s_d.rd_valid = 1'b1;
            s_d.phase = tfp_pkg::TFP_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            // struct cleared first, then ptr, res and phase set to their reset constants, all zero
            s_q <= '0;
            s_q.ptr <= `TFP_PTR_RST;
            s_q.res <= `TFP_RES_RST;
            s_q.phase <= tfp_pkg::TFP_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // every output is a register field; nothing combinational leaves
    assign ptr_o = s_q.ptr;
    assign rdata_o = s_q.rd_data;
    assign rvalid_o = s_q.rd_valid;
    assign wr_strobe_o = s_q.wr_strobe;
    assign wr_addr_o = s_q.wr_addr;
    assign wr_data_o = s_q.wr_data;
    assign local_resolution_select_o = s_q.res;
endmodule

`default_nettype wire

// File: tfp_regs_asserts.sv
// port checks for tfp_regs
// assumes a bind from the bench top; sees design ports only
`default_nettype none
module tfp_regs_asserts (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic ptr_wr_i,
    input wire logic data_wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] ptr_o,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wr_strobe_o,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic [1:0] local_resolution_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    logic only_rd;
    assign only_rd = rd_i && !ptr_wr_i && !data_wr_i;
    sequence ptr_rd_s;
        ptr_wr_i ##1 !ptr_wr_i ##1 only_rd;
    endsequence
    ptr_load_a: assert property (
        ptr_wr_i |=> ptr_o == $past(wdata_i)) else $error("ptr load");
    ptr_hold_a: assert property (
        !ptr_wr_i |=> $stable(ptr_o)) else $error("ptr moved");
    rd_answer_a: assert property (
        only_rd |=> rvalid_o) else $error("no read answer");
    rd_cause_a: assert property (
        rvalid_o |-> $past(rd_i)) else $error("stray rvalid");
    wr_path_a: assert property (
        data_wr_i && !ptr_wr_i |=> wr_strobe_o &&
        wr_addr_o == $past(ptr_o) && wr_data_o == $past(wdata_i))
        else $error("write path");
    rem_low_a: assert property (
        rvalid_o && $past(ptr_o) == 8'h10 |-> rdata_o[3:0] == 4'h0)
        else $error("remote low bits");
    loc_low_a: assert property (
        rvalid_o && $past(ptr_o) == 8'h15 |-> rdata_o[3:0] == 4'h0)
        else $error("local low bits");
    res_read_a: assert property (
        rvalid_o && $past(ptr_o) == 8'h1A |->
        rdata_o == {6'h07, local_resolution_select_o})
        else $error("res read");
    ptr_read_a: assert property (
        ptr_rd_s |=> ptr_o == $past(wdata_i, 3)) else $error("ptr read");
endmodule
`default_nettype wire
